// File: bench/tb.sv
// tb: register-level tests of measure modes and pwm
// assumes: 20 MHz aclk, axi4-lite master tasks, pin source model
`timescale 1ns/1ps
module tb;
    import tmpwm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000, rd, rdv;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, src = 1'b0;
    logic awr, wrd, bv, arr, rv, po, poe, ci, oi, pi;
    logic [1:0] br, rr, resp;
    int bad_count = 0;
    int checks_done = 0;
    int a, b;
    // clock
    always #25 aclk = ~aclk;
    tmpwm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .timer_pin_i(pi),
        .timer_pin_o(po), .timer_pin_oe_n(poe), .compare_irq(ci), .overflow_irq(oi));
    tmpwm_pin_src SRC (.src_lvl(src), .timer_pin_o(po), .timer_pin_oe_n(poe), .pin_i(pi));
    ////////////////////////////////////////////////////////////////////////////////
    // verdict and run end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // compare one value
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // bounded wait ran out
    task automatic limit(input int n);
        if (n >= 200) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : limit
    function automatic logic [31:0] near(logic [31:0] s, logic [31:0] e, int t);
        return ((s + t >= e) && (s <= e + t)) ? 32'h00000001 : 32'h00000000;
    endfunction : near
    // axi4-lite write, response kept in resp
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awa <= ad;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv && n < 200);
        resp = br;
        bry <= 1'b0;
        limit(n);
    endtask : wr
    // axi4-lite read, data in rdv and response in resp
    task automatic rdr(input logic [7:0] ad);
        int n;
        @(posedge aclk);
        ara <= ad;
        arv <= 1'b1;
        rry <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 200);
        rdv = rd;
        resp = rr;
        rry <= 1'b0;
        limit(n);
    endtask : rdr
    // cycles until the pin output changes
    task automatic waitchg(output int c);
        logic p;
        p = po;
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (po === p && c < 200);
        limit(c);
    endtask : waitchg
    // one measurement run: width, period or capture
    task automatic meas(input logic [3:0] m, input logic i, input int k);
        logic [31:0] l1;
        // mode changed only while disabled, old flags cleared
        wr(OFF_CTRL, 32'h00300000);
        src <= i;
        wr(OFF_LOAD, 32'h00000100);
        wr(OFF_CTRL, {22'h0, 1'b0, i, m, 4'b0101});
        repeat ((m == MODE_CAPTURE) ? 2 * k : 10) @(posedge aclk);
        src <= !i;
        if (m != MODE_CAPTURE) begin
            repeat (k) @(posedge aclk);
            if (m == MODE_PERIOD) src <= i;
            repeat (k) @(posedge aclk);
            src <= (m == MODE_PERIOD) ? !i : i;
        end
        repeat (8) @(posedge aclk);
        rdr(OFF_COUNT);
        chk("count", near(rdv, (m == MODE_CAPTURE) ? k + 2 : 256 + k, 2), 1);
        rdr(OFF_CTRL);
        chk("compare flag", rdv[B_TCF], 1'b1);
        chk("compare irq", ci, 1'b1);
        rdr(OFF_LIVE);
        l1 = rdv;
        rdr(OFF_LIVE);
        chk("live moves", rdv != l1, m != MODE_CAPTURE);
    endtask : meas
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int j = 0; j < 5; j++) begin
            rdr(8'(4 * j));
            chk("reset value", rdv, RST_VAL);
        end
        rdr(8'h14);
        chk("unmapped resp", resp, RESP_SLVERR);
        wr(8'h20, 32'h00000005);
        chk("bad write resp", resp, RESP_SLVERR);
        wr(OFF_COUNT, 32'h00001234);
        rdr(OFF_COUNT);
        chk("count read only", rdv, 32'h00000000);
        wr(OFF_LOAD, 32'hffffffff);
        rdr(OFF_LOAD);
        chk("load width", rdv, 32'h00ffffff);
        for (int i = 0; i < 2; i++) begin
            for (int m = 4; m < 7; m++) meas(4'(m), i[0], 20 + 4 * m);
        end
        wr(OFF_LOAD, 32'h00fffff0);
        wr(OFF_CMP, 32'h00fffff8);
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CTRL, 32'h00300000);
            wr(OFF_CTRL, {22'h0, 1'b1, i[0], MODE_PWM, 4'b0111});
            // drive enable follows the enable bit by one cycle
            @(posedge aclk);
            chk("pin start", po, i[0]);
            chk("pin driven", poe, 1'b0);
            waitchg(a);
            waitchg(a);
            waitchg(b);
            chk("period", 32'(a + b), 32'h00000020);
            chk("duty", near(32'((a < b) ? a : b), 14, 2), 1);
            rdr(OFF_COUNT);
            chk("match count", rdv, 32'h00fffff8);
            rdr(OFF_CTRL);
            chk("flags", rdv[B_TCF:B_TOF], 2'b11);
            chk("overflow irq", oi, 1'b1);
        end
        wr(OFF_CTRL, 32'h00300000);
        wr(OFF_CTRL, 32'h00000077);
        a = 0;
        while (!oi && a < 200) begin
            @(posedge aclk);
            a++;
        end
        limit(a);
        rdr(OFF_COUNT);
        chk("overflow count", rdv, 32'h00fffff0);
        wr(OFF_CTRL, 32'h00100077);
        repeat (2) @(posedge aclk);
        chk("overflow cleared", oi, 1'b0);
        wr(OFF_CTRL, 32'h00000000);
        repeat (2) @(posedge aclk);
        chk("pin released", poe, 1'b1);
        tally_and_finish();
    end
endmodule : tb

// File: bench/tmpwm_pin_src.sv
// tmpwm_pin_src: external signal source or load on the timer pin
// assumes: bench sets the source level; device drives only in pwm
`timescale 1ns/1ps
module tmpwm_pin_src (
    input wire logic src_lvl, // level the source offers
    input wire logic timer_pin_o, // device drive value
    input wire logic timer_pin_oe_n, // device drive, low drives
    output logic pin_i // resolved wire level
);
    // wire resolution: source yields while the device drives
    assign pin_i = timer_pin_oe_n ? src_lvl : timer_pin_o;
endmodule : tmpwm_pin_src

// File: bench/tmpwm_props.sv
// tmpwm_props: port-level checks for the timer measure/pwm block
// assumes: bound into tmpwm_top, one clock, sync active-low reset
`timescale 1ns/1ps
module tmpwm_props
    import tmpwm_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // read response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic timer_pin_o, // pin out
    input wire logic timer_pin_oe_n // pin drive, low drives
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake holds and latencies, pin toggle rate
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data not held");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
    wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    pin_rate_a: assert property (!timer_pin_oe_n && $past(!timer_pin_oe_n)
        && $changed(timer_pin_o) |=> $stable(timer_pin_o))
        else $error("pin toggled faster than timer clock");
endmodule : tmpwm_props
bind tmpwm_top tmpwm_props chk_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_pin_o(timer_pin_o),
    .timer_pin_oe_n(timer_pin_oe_n));

// File: verilog/tmpwm_pkg.sv
// tmpwm_pkg: register map, field layout, modes and timing for the timer measure/pwm block
// assumes: 32-bit axi4-lite slave, 20 MHz aclk
package tmpwm_pkg;
    localparam int CNT_W = 24;
    localparam logic [23:0] CNT_ONES = 24'hffffff;
    // byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOAD = 8'h04;
    localparam logic [7:0] OFF_CMP = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_LIVE = 8'h10;
    // control/status field positions
    localparam int B_TE = 0;
    localparam int B_OVERFLOW_IRQ_ENABLE = 1;
    localparam int B_COMPARE_IRQ_ENABLE = 2;
    localparam int B_MODE_LO = 4;
    localparam int B_INV = 8;
    localparam int B_TRM = 9;
    localparam int B_TOF = 20;
    localparam int B_TCF = 21;
    localparam int B_PIN = 22;
    localparam int B_IRQ_OV = 23;
    localparam int B_IRQ_CMP = 24;
    // mode codes
    localparam logic [3:0] MODE_WIDTH = 4'h4;
    localparam logic [3:0] MODE_PERIOD = 4'h5;
    localparam logic [3:0] MODE_CAPTURE = 4'h6;
    localparam logic [3:0] MODE_PWM = 4'h7;
    // timer clock is half the internal clock
    localparam int CLK_HZ = 20000000;
    localparam int TCLK_DIV = 2;
    localparam logic [31:0] RST_VAL = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {TMPWM_IDLE, TMPWM_RUN, TMPWM_HALT} tmpwm_state_t;
endpackage : tmpwm_pkg

// File: verilog/tmpwm_sync.sv
// tmpwm_sync: two-flop synchroniser with edge detect on the second stage
// assumes: pin input asynchronous to aclk
`timescale 1ns/1ps
module tmpwm_sync (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic din, // raw pin level
    output logic dout, // synchronised level
    output logic rise, // rising edge pulse
    output logic fall // falling edge pulse
);
    logic s1_reg, s2_reg, s3_reg;
    logic s1_next, s2_next, s3_next;
    // next values of the chain
    always_comb begin
        s1_next = din;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end
    // register chain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end
    assign dout = s2_reg;
    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;
endmodule : tmpwm_sync

// File: verilog/tmpwm_top.sv
// tmpwm_top: one timer channel, width/period/capture measurement and pwm
// assumes: axi4-lite master on aclk; pin wired through an external buffer
//
// Functional notes
// - mode field picks width, period, capture, pwm
// - pin synchronised to clock before use
// - width: start edge by polarity loads counter
// - width: opposite edge captures, flags; stops only with reload
// - width: reload on next start edge
// - period: same-polarity edges, first loads counter
// - period: next edge flags and captures count
// - period: reload restarts, else count to overflow
// - capture: count to edge, flag, halt, capture
// - capture: polarity selects ending edge
// - pwm: compare match toggles pin, flags, captures
// - pwm: overflow toggles, flags, optional reload
// - pwm: pin starts at polarity value
// - 24-bit counter, overflow past all ones
// - pwm duty set by compare value
// - pwm no-reload overflow loads count register
// - enable set clears counter and starts pwm and capture; width and period wait for their first edge
// - count readable anytime without disturbing
`timescale 1ns/1ps
module tmpwm_top
    import tmpwm_pkg::*;
(
    input wire logic aclk, // 20 MHz clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic timer_pin_i, // pin level in
    output logic timer_pin_o, // pin level out
    output logic timer_pin_oe_n, // pin drive enable, low drives
    output logic compare_irq, // compare interrupt request
    output logic overflow_irq // overflow interrupt request
);
    localparam int TCLK_HZ = CLK_HZ / TCLK_DIV;

    // strobe merge for one register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic pin_s, pin_rise, pin_fall;
    tmpwm_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(timer_pin_i),
        .dout(pin_s),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic te_reg, te_next, overflow_irq_enable_reg, overflow_irq_enable_next, compare_irq_enable_reg, compare_irq_enable_next;
    logic inv_reg, inv_next, trm_reg, trm_next;
    logic [3:0] mode_reg, mode_next;
    logic tof_reg, tof_next, tcf_reg, tcf_next;
    logic [23:0] load_reg, load_next, cmp_reg, cmp_next, cnt_reg, cnt_next;
    logic [23:0] count_reg, count_next;
    logic pin_reg, pin_next, oe_n_reg, oe_n_next;
    logic div_reg, div_next;
    logic reload_reg, reload_next;
    tmpwm_state_t st_reg, st_next;
    logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
    logic ar_reg, ar_next, rv_reg, rv_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic cirq_reg, cirq_next, oirq_reg, oirq_next;

    logic [7:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next;
    logic have_aw_reg, have_aw_next, have_w_reg, have_w_next;

    logic [31:0] ctrl_word;
    logic start_edge, stop_edge, tick, do_wr, wr_ctrl, clr_tof, clr_tcf;
    logic set_tcf, set_tof;
    logic [31:0] wmerged;

    // control/status as seen by software
    always_comb begin
        ctrl_word = '0;
        ctrl_word[B_TE] = te_reg;
        ctrl_word[B_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable_reg;
        ctrl_word[B_COMPARE_IRQ_ENABLE] = compare_irq_enable_reg;
        ctrl_word[B_MODE_LO +: 4] = mode_reg;
        ctrl_word[B_INV] = inv_reg;
        ctrl_word[B_TRM] = trm_reg;
        ctrl_word[B_TOF] = tof_reg;
        ctrl_word[B_TCF] = tcf_reg;
        ctrl_word[B_PIN] = pin_s;
        ctrl_word[B_IRQ_OV] = oirq_reg;
        ctrl_word[B_IRQ_CMP] = cirq_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data taken in either order
    always_comb begin
        have_aw_next = have_aw_reg;
        have_w_next = have_w_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        bv_next = bv_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awr_reg) begin
            have_aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wr_reg) begin
            have_w_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        do_wr = have_aw_reg && have_w_reg && !bv_reg;
        if (do_wr) begin
            have_aw_next = 1'b0;
            have_w_next = 1'b0;
            bv_next = 1'b1;
            bresp_next = (awa_reg[7:2] <= OFF_COUNT[7:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        // channels stay closed until the response has been taken
        awr_next = ~have_aw_next & ~bv_next;
        wr_next = ~have_w_next & ~bv_next;
        wmerged = merge(ctrl_word, wd_reg, ws_reg);
        wr_ctrl = do_wr && awa_reg == OFF_CTRL;
        // status flags clear by writing one
        clr_tof = wr_ctrl && ws_reg[B_TOF/8] && wd_reg[B_TOF];
        clr_tcf = wr_ctrl && ws_reg[B_TCF/8] && wd_reg[B_TCF];
    end

    always_comb begin
        ar_next = ar_reg;
        rv_next = rv_reg;
        rd_next = rd_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && ar_reg) begin
            ar_next = 1'b0;
            rv_next = 1'b1;
            rresp_next = RESP_OKAY;
            unique case (s_axi_araddr)
                OFF_CTRL: rd_next = ctrl_word;
                OFF_LOAD: rd_next = {8'h00, load_reg};
                OFF_CMP: rd_next = {8'h00, cmp_reg};
                OFF_COUNT: rd_next = {8'h00, count_reg};
                OFF_LIVE: rd_next = {8'h00, cnt_reg};
                default: begin
                    rd_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
            ar_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer core
    always_comb begin
        te_next = te_reg;
        overflow_irq_enable_next = overflow_irq_enable_reg;
        compare_irq_enable_next = compare_irq_enable_reg;
        mode_next = mode_reg;
        inv_next = inv_reg;
        trm_next = trm_reg;
        load_next = load_reg;
        cmp_next = cmp_reg;
        cnt_next = cnt_reg;
        count_next = count_reg;
        pin_next = pin_reg;
        oe_n_next = (mode_reg != MODE_PWM) | ~te_reg;
        st_next = st_reg;
        reload_next = reload_reg;
        set_tcf = 1'b0;
        set_tof = 1'b0;
        // timer clock is half the internal clock
        div_next = te_reg ? ~div_reg : 1'b0;
        tick = te_reg && div_reg;
        start_edge = inv_reg ? pin_fall : pin_rise;
        stop_edge = inv_reg ? pin_rise : pin_fall;
        if (wr_ctrl) begin
            te_next = wmerged[B_TE];
            overflow_irq_enable_next = wmerged[B_OVERFLOW_IRQ_ENABLE];
            compare_irq_enable_next = wmerged[B_COMPARE_IRQ_ENABLE];
            mode_next = wmerged[B_MODE_LO +: 4];
            inv_next = wmerged[B_INV];
            trm_next = wmerged[B_TRM];
        end
        if (do_wr && awa_reg == OFF_LOAD) begin
            load_next = 24'(merge({8'h00, load_reg}, wd_reg, ws_reg));
        end
        if (do_wr && awa_reg == OFF_CMP) begin
            cmp_next = 24'(merge({8'h00, cmp_reg}, wd_reg, ws_reg));
        end
        if (!te_reg) begin
            st_next = TMPWM_IDLE;
            if (te_next) begin
                cnt_next = '0;
                div_next = 1'b0;
                reload_next = 1'b0;
                pin_next = wmerged[B_INV];
                // width and period wait for an edge, pwm and capture run at once
                st_next = (wmerged[B_MODE_LO +: 4] == MODE_PWM ||
                           wmerged[B_MODE_LO +: 4] == MODE_CAPTURE) ?
                          TMPWM_RUN : TMPWM_IDLE;
                // pwm loads the load value on its first clock
                reload_next = wmerged[B_MODE_LO +: 4] == MODE_PWM;
            end
        end else begin
            unique case (mode_reg)
                MODE_WIDTH: begin
                    // no reload keeps counting, halt waits for start edge
                    if (tick && st_reg != TMPWM_HALT) begin
                        cnt_next = cnt_reg + 24'h000001;
                    end
                    // start edge load wins over the tick above
                    if (st_reg != TMPWM_RUN && start_edge) begin
                        cnt_next = load_reg;
                        st_next = TMPWM_RUN;
                    end else if (st_reg == TMPWM_RUN && stop_edge) begin
                        count_next = cnt_reg;
                        set_tcf = 1'b1;
                        st_next = trm_reg ? TMPWM_HALT : TMPWM_IDLE;
                    end
                end
                MODE_PERIOD: begin
                    if (start_edge) begin
                        if (st_reg == TMPWM_RUN) begin
                            count_next = cnt_reg;
                            set_tcf = 1'b1;
                        end
                        if (st_reg != TMPWM_RUN || trm_reg) begin
                            cnt_next = trm_reg && st_reg == TMPWM_RUN ? '0 : load_reg;
                        end
                        st_next = TMPWM_RUN;
                    end else if (tick && st_reg == TMPWM_RUN) begin
                        cnt_next = cnt_reg + 24'h000001;
                        if (cnt_reg == CNT_ONES) begin
                            set_tof = 1'b1;
                        end
                    end
                end
                MODE_CAPTURE: begin
                    if (st_reg == TMPWM_RUN && start_edge) begin
                        count_next = cnt_reg;
                        set_tcf = 1'b1;
                        st_next = TMPWM_HALT;
                    end else if (tick && st_reg == TMPWM_RUN) begin
                        cnt_next = cnt_reg + 24'h000001;
                    end
                end
                MODE_PWM: begin
                    if (tick) begin
                        if (reload_reg) begin
                            // first timer clock loads load value
                            cnt_next = load_reg;
                            reload_next = 1'b0;
                        end else begin
                            cnt_next = cnt_reg + 24'h000001;
                            if (cnt_next == cmp_reg) begin
                                pin_next = ~pin_reg;
                                set_tcf = 1'b1;
                                count_next = cnt_next;
                            end
                            if (cnt_reg == CNT_ONES) begin
                                pin_next = ~pin_reg;
                                set_tof = 1'b1;
                                // reload keeps period at ones minus load plus one
                                if (trm_reg) begin
                                    cnt_next = load_reg;
                                end
                                if (!trm_reg) begin
                                    count_next = load_reg;
                                end
                            end
                        end
                    end
                end
                default: begin
                    st_next = TMPWM_IDLE;
                end
            endcase
        end
        // flag sets win over software clears
        tcf_next = set_tcf | (tcf_reg & ~clr_tcf);
        tof_next = set_tof | (tof_reg & ~clr_tof);
        cirq_next = tcf_next & compare_irq_enable_next;
        oirq_next = tof_next & overflow_irq_enable_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {te_reg, overflow_irq_enable_reg, compare_irq_enable_reg, inv_reg, trm_reg} <= 5'h00;
            mode_reg <= 4'h0;
            {tof_reg, tcf_reg, cirq_reg, oirq_reg} <= 4'h0;
            load_reg <= RST_VAL[23:0];
            cmp_reg <= RST_VAL[23:0];
            cnt_reg <= RST_VAL[23:0];
            count_reg <= RST_VAL[23:0];
            pin_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            div_reg <= 1'b0;
            reload_reg <= 1'b0;
            st_reg <= TMPWM_IDLE;
            {awr_reg, wr_reg, ar_reg} <= 3'h7;
            {bv_reg, rv_reg, have_aw_reg, have_w_reg} <= 4'h0;
            rd_reg <= RST_VAL;
            {bresp_reg, rresp_reg} <= 4'h0;
            awa_reg <= 8'h00;
            wd_reg <= RST_VAL;
            ws_reg <= 4'h0;
        end else begin
            {te_reg, overflow_irq_enable_reg, compare_irq_enable_reg, inv_reg, trm_reg} <=
                {te_next, overflow_irq_enable_next, compare_irq_enable_next, inv_next, trm_next};
            mode_reg <= mode_next;
            {tof_reg, tcf_reg, cirq_reg, oirq_reg} <= {tof_next, tcf_next, cirq_next, oirq_next};
            load_reg <= load_next;
            cmp_reg <= cmp_next;
            cnt_reg <= cnt_next;
            count_reg <= count_next;
            pin_reg <= pin_next;
            oe_n_reg <= oe_n_next;
            div_reg <= div_next;
            reload_reg <= reload_next;
            st_reg <= st_next;
            {awr_reg, wr_reg, ar_reg} <= {awr_next, wr_next, ar_next};
            {bv_reg, rv_reg, have_aw_reg, have_w_reg} <=
                {bv_next, rv_next, have_aw_next, have_w_next};
            rd_reg <= rd_next;
            {bresp_reg, rresp_reg} <= {bresp_next, rresp_next};
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
        end
    end

    // outputs straight from flops
    assign s_axi_awready = awr_reg;
    assign s_axi_wready = wr_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rresp_reg;
    assign timer_pin_o = pin_reg;
    assign timer_pin_oe_n = oe_n_reg;
    assign compare_irq = cirq_reg;
    assign overflow_irq = oirq_reg;
endmodule : tmpwm_top
